/* design/sfrc_device.sv */
// Device end: power-on, hardware and software reset control of a serial flash
module sfrc_device
   import sfrc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   sfrc_link_if.dev         link,
   input  wire logic        quad_enable_bit_in,
   input  wire logic        quad_command_enable_bit_in,
   input  wire logic        shared_reset_enable_nv_bit_in,
   input  wire logic        por_fail_in,
   output logic             in_reset_out,
   output logic             standby_out,
   output logic             deep_sleep_mode_out,
   output logic             sw_reset_pulse_out,
   output logic [7:0]       last_cmd_out
);
   typedef enum logic [1:0] {D_POR, D_HWRST, D_RUN} sfrc_dev_e;
   sfrc_dev_e        st_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] low_r;
   logic [CNT_W-1:0] csh_r;
   logic [2:0]       s1_r, s2_r, s3_r;
   logic             sel_n, sck, rst_n, d3;
   logic             sck_d_r, sel_d_r;
   logic [7:0]       sh_r;
   logic [3:0]       bit_r;
   logic             reset_enable_cmd_r;
   logic             por_ok_r;
   logic             quad_rd_r;
   logic             d3_oe_r;
   logic             si_s1_r, si_s2_r;
   logic [7:0]       byte_nxt;

   // ---------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1_r <= 3'h5; s2_r <= 3'h5; s3_r <= 3'h7;
         si_s1_r <= 1'b0; si_s2_r <= 1'b0;
      end else begin
         si_s1_r <= link.si;
         si_s2_r <= si_s1_r;
         s1_r <= {link.select_n, link.sck, link.hw_reset_n};
         s2_r <= s1_r;
         s3_r <= {link.shared_data3_reset_pin, s3_r[2:1]};
      end
   end
   assign sel_n = s2_r[2];
   assign sck   = s2_r[1];
   assign rst_n = s2_r[0];
   assign d3    = s3_r[1];
   // Serial data is delayed by the same two stages as the link clock
   assign byte_nxt = {sh_r[6:0], si_s2_r};

   // Shared pin counts as reset only when permitted
   logic d3_armed;
   assign d3_armed = shared_reset_enable_nv_bit_in &&
                     (!(quad_enable_bit_in || quad_command_enable_bit_in) ||
                      (sel_n && csh_r >= CNT_W'(CS_CYC)));
   logic rst_low;
   assign rst_low = !rst_n || (d3_armed && !d3);

   // ---------------------------------------------
   // Select-high and reset-low counters
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         csh_r <= '0; low_r <= '0; sck_d_r <= 1'b0; sel_d_r <= 1'b1;
      end else begin
         sck_d_r <= sck;
         sel_d_r <= sel_n;
         csh_r <= !sel_n ? '0 : (csh_r == '1 ? csh_r : csh_r + 1'b1);
         low_r <= !rst_low ? '0 : (low_r == '1 ? low_r : low_r + 1'b1);
      end
   end

   // ---------------------------------------------
   // Reset sequencer
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r <= D_POR; cnt_r <= '0; por_ok_r <= 1'b0;
         in_reset_out <= 1'b1; standby_out <= 1'b0;
      end else begin
         unique case (st_r)
            D_POR: begin
               if (cnt_r >= CNT_W'(PU_CYC)) begin
                  if (!rst_low) begin
                     st_r <= D_RUN; por_ok_r <= !por_fail_in;
                     in_reset_out <= 1'b0; standby_out <= 1'b1;
                  end
               end else cnt_r <= cnt_r + 1'b1;
            end
            D_HWRST: begin
               if (cnt_r >= CNT_W'(RPH_CYC) && !rst_low) begin
                  st_r <= D_RUN; in_reset_out <= 1'b0; standby_out <= 1'b1;
               end else if (cnt_r < CNT_W'(RPH_CYC)) cnt_r <= cnt_r + 1'b1;
            end
            D_RUN: begin
               standby_out <= sel_n;
               if (low_r == CNT_W'(RP_CYC)) begin
                  cnt_r <= '0; in_reset_out <= 1'b1; standby_out <= 1'b0;
                  st_r <= por_ok_r ? D_HWRST : D_POR;
               end
            end
            default: st_r <= D_POR;
         endcase
      end
   end

   // ---------------------------------------------
   // Command decode, software reset and deep sleep
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sh_r <= '0; bit_r <= '0; reset_enable_cmd_r <= 1'b0; deep_sleep_mode_out <= 1'b0;
         sw_reset_pulse_out <= 1'b0; last_cmd_out <= '0; quad_rd_r <= 1'b0;
      end else begin
         sw_reset_pulse_out <= 1'b0;
         if (st_r != D_RUN) begin
            bit_r <= '0; reset_enable_cmd_r <= 1'b0; deep_sleep_mode_out <= 1'b0; quad_rd_r <= 1'b0;
         end else if (sel_n) begin
            bit_r <= '0;
         end else if (sck && !sck_d_r && bit_r != 4'h8) begin
            sh_r <= byte_nxt;
            bit_r <= bit_r + 1'b1;
            if (bit_r == 4'h7) begin
               last_cmd_out <= byte_nxt;
               if (deep_sleep_mode_out) begin
                  if (byte_nxt == CMD_WAKE) deep_sleep_mode_out <= 1'b0;
               end else begin
                  reset_enable_cmd_r <= (byte_nxt == CMD_RESET_EN);
                  if (reset_enable_cmd_r && byte_nxt == CMD_RESET) sw_reset_pulse_out <= 1'b1;
                  if (byte_nxt == CMD_SLEEP) deep_sleep_mode_out <= 1'b1;
                  quad_rd_r <= (byte_nxt == CMD_QREAD) &&
                               (quad_enable_bit_in || quad_command_enable_bit_in);
               end
            end
         end
      end
   end

   // ---------------------------------------------
   // Shared pin drive after quad read
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) d3_oe_r <= 1'b0;
      else d3_oe_r <= quad_rd_r && sel_n && !sel_d_r ? 1'b1 :
                      (sel_n && csh_r < CNT_W'(CS_CYC) && st_r == D_RUN) ? d3_oe_r : 1'b0;
   end
   assign link.d3_dev_out = 1'b1;
   assign link.d3_dev_oe  = d3_oe_r;
endmodule : sfrc_device

/* design/sfrc_host.sv */
// Host end: drives select, clock, commands and reset pulses with the required spacing
module sfrc_host
   import sfrc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   sfrc_link_if.host        link,
   input  wire logic        cmd_valid_in,
   input  wire logic [7:0]  cmd_byte_in,
   input  wire logic        hw_reset_req_in,
   output logic             ready_out,
   output logic             busy_out
);
   typedef enum logic [2:0] {H_PWRUP, H_IDLE, H_SEL, H_SHIFT, H_DESEL, H_RSTLOW, H_RSTHOLD} sfrc_hst_e;
   sfrc_hst_e        st_r;
   logic [CNT_W-1:0] cnt_r;
   logic [7:0]       sh_r;
   logic [3:0]       bit_r;
   logic [2:0]       div_r;
   logic             sck_r;
   logic             sel_n_r;
   logic             rst_n_r;

   assign link.select_n    = sel_n_r;
   assign link.sck         = sck_r;
   assign link.si          = sh_r[7];
   assign link.hw_reset_n  = rst_n_r;
   assign link.d3_host_out = 1'b1;
   assign link.d3_host_oe  = 1'b0;

   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r <= H_PWRUP; cnt_r <= '0; sh_r <= '0; bit_r <= '0; div_r <= '0;
         sck_r <= 1'b0; sel_n_r <= 1'b1; rst_n_r <= 1'b1;
         ready_out <= 1'b0; busy_out <= 1'b1;
      end else begin
         unique case (st_r)
            H_PWRUP: begin
               if (cnt_r == CNT_W'(PU_CYC + RS_CYC)) begin
                  st_r <= H_IDLE; ready_out <= 1'b1; busy_out <= 1'b0; cnt_r <= '0;
               end else cnt_r <= cnt_r + 1'b1;
            end
            H_IDLE: begin
               if (hw_reset_req_in) begin
                  rst_n_r <= 1'b0; sel_n_r <= 1'b1; cnt_r <= '0; st_r <= H_RSTLOW;
                  ready_out <= 1'b0; busy_out <= 1'b1;
               end else if (cmd_valid_in) begin
                  sh_r <= cmd_byte_in; sel_n_r <= 1'b0; bit_r <= '0; div_r <= '0;
                  st_r <= H_SEL; ready_out <= 1'b0; busy_out <= 1'b1;
               end
            end
            H_SEL: st_r <= H_SHIFT;
            H_SHIFT: begin
               if (div_r == 3'(SCK_HALF - 1)) begin
                  div_r <= '0;
                  sck_r <= ~sck_r;
                  if (sck_r) begin
                     sh_r <= {sh_r[6:0], 1'b0};
                     bit_r <= bit_r + 1'b1;
                     if (bit_r == 4'h7) begin st_r <= H_DESEL; cnt_r <= '0; end
                  end
               end else div_r <= div_r + 1'b1;
            end
            H_DESEL: begin
               sel_n_r <= 1'b1;
               if (cnt_r == CNT_W'(CS_CYC)) begin
                  st_r <= H_IDLE; ready_out <= 1'b1; busy_out <= 1'b0;
               end else cnt_r <= cnt_r + 1'b1;
            end
            H_RSTLOW: begin
               if (cnt_r == CNT_W'(RP_CYC)) begin
                  rst_n_r <= 1'b1; cnt_r <= '0; st_r <= H_RSTHOLD;
               end else cnt_r <= cnt_r + 1'b1;
            end
            H_RSTHOLD: begin
               if (cnt_r + CNT_W'(RP_CYC) >= CNT_W'(RPH_CYC + RH_CYC + RS_CYC)) begin
                  st_r <= H_IDLE; ready_out <= 1'b1; busy_out <= 1'b0;
               end else cnt_r <= cnt_r + 1'b1;
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end
endmodule : sfrc_host

/* design/sfrc_link_if.sv */
// Serial memory link between host and flash reset control
interface sfrc_link_if;
   logic select_n;
   logic sck;
   logic si;
   logic hw_reset_n;
   logic d3_host_out;
   logic d3_host_oe;
   logic d3_dev_out;
   logic d3_dev_oe;
   logic shared_data3_reset_pin;
   // Pull-up keeps the shared pin high when nobody drives it
   assign shared_data3_reset_pin = d3_dev_oe ? d3_dev_out : (d3_host_oe ? d3_host_out : 1'b1);
   modport dev  (input select_n, sck, si, hw_reset_n, shared_data3_reset_pin, output d3_dev_out, d3_dev_oe);
   modport host (output select_n, sck, si, hw_reset_n, d3_host_out, d3_host_oe, input shared_data3_reset_pin);
endinterface : sfrc_link_if

/* design/sfrc_pkg.sv */
// Shared constants for the serial flash reset control link
package sfrc_pkg;
   localparam int unsigned CLK_MHZ          = 100;
   // Times in ns / us as printed
   localparam int unsigned T_RS_NS          = 50;
   localparam int unsigned T_RH_NS          = 50;
   localparam int unsigned T_RP_NS          = 200;
   localparam int unsigned T_RPH_US         = 35;
   localparam int unsigned T_CS_NS          = 50;
   localparam int unsigned T_PU_US          = 300;
   // Least times round up
   localparam int unsigned RS_CYC           = (T_RS_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RH_CYC           = (T_RH_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RP_CYC           = (T_RP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RPH_CYC          = T_RPH_US * CLK_MHZ;
   localparam int unsigned CS_CYC           = (T_CS_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned PU_CYC           = T_PU_US * CLK_MHZ;
   localparam int unsigned CNT_W            = 24;
   localparam int unsigned SCK_HALF         = 6;
   // Commands
   localparam logic [7:0]  CMD_RESET_EN     = 8'h66;
   localparam logic [7:0]  CMD_RESET        = 8'h99;
   localparam logic [7:0]  CMD_WAKE         = 8'hab;
   localparam logic [7:0]  CMD_SLEEP        = 8'hb9;
   localparam logic [7:0]  CMD_QREAD        = 8'heb;
endpackage : sfrc_pkg

/* test/serial_flash_reset_control_tb.sv */
// Self-checking bench for the flash reset control link
module serial_flash_reset_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sfrc_pkg::*;
   logic       clk_in, nrst_in, cmd_valid, hw_req, quad_en, ready, busy;
   logic       in_reset, standby, sleep, sw_pulse;
   logic [7:0] cmd_byte, last_cmd;
   int         err_total = 0, n_tests = 0, pulses = 0, cyc = 0, len, d3_hits = 0;
   sfrc_link_if link ();
   sfrc_host u_sfrc_host (.clk_in(clk_in), .nrst_in(nrst_in), .link(link), .cmd_valid_in(cmd_valid),
      .cmd_byte_in(cmd_byte), .hw_reset_req_in(hw_req), .ready_out(ready), .busy_out(busy));
   sfrc_device u_sfrc_device (.clk_in(clk_in), .nrst_in(nrst_in), .link(link), .quad_enable_bit_in(quad_en),
      .quad_command_enable_bit_in(quad_en), .shared_reset_enable_nv_bit_in(1'b1), .por_fail_in(1'b0),
      .in_reset_out(in_reset), .standby_out(standby), .deep_sleep_mode_out(sleep),
      .sw_reset_pulse_out(sw_pulse), .last_cmd_out(last_cmd));
   sfrc_link_sva u_sfrc_link_sva (.clk_in(clk_in), .nrst_in(nrst_in), .select_n(link.select_n),
      .hw_reset_n(link.hw_reset_n), .d3_host_oe(link.d3_host_oe), .d3_dev_out(link.d3_dev_out),
      .d3_dev_oe(link.d3_dev_oe), .shared_data3_reset_pin(link.shared_data3_reset_pin));
   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_ready();
      while (ready !== 1'b1) @(posedge clk_in);
   endtask : wait_ready
   task automatic send_cmd(input logic [7:0] b);
      wait_ready();
      cmd_valid <= 1'b1;
      cmd_byte  <= b;
      @(posedge clk_in);
      cmd_valid <= 1'b0;
      @(posedge clk_in);
      wait_ready();
   endtask : send_cmd
   task automatic hw_reset(output int n);
      wait_ready();
      hw_req <= 1'b1;
      @(posedge clk_in);
      hw_req <= 1'b0;
      n = 0;
      while (link.hw_reset_n !== 1'b0) @(posedge clk_in);
      while (in_reset !== 1'b1) begin
         @(posedge clk_in);
         n++;
      end
      while (in_reset !== 1'b0) begin
         @(posedge clk_in);
         n++;
      end
      wait_ready();
   endtask : hw_reset
   // ------------------------------------------------
   // Clock, watchdog and sequence
   // ------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (sw_pulse === 1'b1) pulses <= pulses + 1;
      if (link.d3_dev_oe === 1'b1 && link.shared_data3_reset_pin === 1'b1) d3_hits <= d3_hits + 1;
      if (cyc == 60000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      nrst_in = 1'b0;
      cmd_valid = 1'b0;
      cmd_byte = 8'h00;
      hw_req = 1'b0;
      quad_en = 1'b0;
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (100) @(posedge clk_in);
      check("in_reset in power-up", in_reset, 1);
      wait_ready();
      check("in_reset after power-up", in_reset, 0);
      send_cmd(CMD_RESET_EN);
      send_cmd(CMD_RESET);
      check("soft reset pulses", pulses, 1);
      check("last command", last_cmd, CMD_RESET);
      send_cmd(CMD_RESET);
      check("lone reset command", pulses, 1);
      send_cmd(CMD_SLEEP);
      check("deep sleep entered", sleep, 1);
      send_cmd(CMD_RESET_EN);
      send_cmd(CMD_RESET);
      check("reset ignored asleep", pulses, 1);
      send_cmd(CMD_WAKE);
      check("deep sleep left", sleep, 0);
      quad_en <= 1'b1;
      send_cmd(CMD_QREAD);
      check("data3 after quad read", link.shared_data3_reset_pin, 1);
      check("data3 driven high after quad read", d3_hits > 0, 1);
      quad_en <= 1'b0;
      send_cmd(CMD_SLEEP);
      hw_reset(len);
      check("reset hold length", len >= RPH_CYC, 1);
      check("sleep cleared by reset", sleep, 0);
      check("standby after reset", standby, 1);
      send_cmd(CMD_RESET_EN);
      send_cmd(CMD_RESET);
      check("soft reset after hw reset", pulses, 2);
      finish_test();
   end
endmodule : serial_flash_reset_control_tb

/* test/sfrc_link_sva.sv */
// Assertion checker for the flash reset control link
module sfrc_link_sva
   import sfrc_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic nrst_in,
   input  wire logic select_n,
   input  wire logic hw_reset_n,
   input  wire logic d3_host_oe,
   input  wire logic d3_dev_out,
   input  wire logic d3_dev_oe,
   input  wire logic shared_data3_reset_pin
);
   // ------------------------------------------------
   // Cycle counters
   // ------------------------------------------------
   logic [CNT_W-1:0] up_r;
   logic [CNT_W-1:0] hi_r;
   logic [CNT_W-1:0] lo_r;
   logic [CNT_W-1:0] since_r;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         up_r    <= '0;
         hi_r    <= '0;
         lo_r    <= '0;
         since_r <= CNT_W'(RPH_CYC);
      end else begin
         up_r    <= up_r + 1'b1;
         hi_r    <= hw_reset_n ? hi_r + 1'b1 : '0;
         lo_r    <= hw_reset_n ? '0 : lo_r + 1'b1;
         since_r <= (hw_reset_n || lo_r != '0) ? since_r + 1'b1 : '0;
      end
   end
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   sequence rst_fall_s; $fell(hw_reset_n); endsequence
   sequence sel_open_s; $fell(select_n); endsequence
   sel_powerup_a: assert property (up_r < CNT_W'(PU_CYC) |-> select_n)
      else $error("select during power-up");
   rst_setup_a: assert property (rst_fall_s |-> $past(hi_r) >= RS_CYC)
      else $error("reset low too soon");
   pulse_width_a: assert property ($rose(hw_reset_n) |-> $past(lo_r) >= RP_CYC)
      else $error("reset pulse too short");
   sel_after_rst_a: assert property (sel_open_s |-> since_r >= RPH_CYC && hi_r >= RH_CYC)
      else $error("select too soon after reset");
   cs_high_a: assert property ($rose(select_n) |-> select_n [*5])
      else $error("select high time too short");
   pull_up_a: assert property (!d3_dev_oe && !d3_host_oe |-> shared_data3_reset_pin)
      else $error("shared pin not pulled high");
   no_contend_a: assert property (!(d3_dev_oe && d3_host_oe))
      else $error("both ends drive data3");
   d3_high_a: assert property (d3_dev_oe && select_n |-> d3_dev_out)
      else $error("data3 driven low while deselected");
   reset_tristate_a: assert property (lo_r >= RP_CYC + 4 |-> !d3_dev_oe)
      else $error("data3 driven during reset");
endmodule : sfrc_link_sva
